// ---- rtl/sms_pkg.sv ----
////////////////////////////////////////////////////////////////////////////////
// Shared constants and types of the signal measurement timer source block.
////////////////////////////////////////////////////////////////////////////////
package sms_pkg;

    // Byte addresses of the registers, one aligned 32-bit word each.
    localparam logic [5:0] ADDR_CLOCK_SEL = 6'h00;
    localparam logic [5:0] ADDR_WINDOW_SEL = 6'h04;
    localparam logic [5:0] ADDR_SIGNAL_SEL = 6'h08;
    localparam logic [5:0] ADDR_COUNT_LOW = 6'h0C;
    localparam logic [5:0] ADDR_COUNT_HIGH = 6'h10;
    localparam logic [5:0] ADDR_COUNT_UPPER = 6'h14;
    localparam logic [5:0] ADDR_CAP_PERIOD_LOW = 6'h18;
    localparam logic [5:0] ADDR_CAP_PERIOD_HIGH = 6'h1C;
    localparam logic [5:0] ADDR_CAP_PERIOD_UPPER = 6'h20;
    localparam logic [5:0] ADDR_CAP_WIDTH_LOW = 6'h24;
    localparam logic [5:0] ADDR_CONTROL = 6'h28;
    localparam logic [5:0] ADDR_PERIOD_LOW = 6'h2C;
    localparam logic [5:0] ADDR_PERIOD_HIGH = 6'h30;
    localparam logic [5:0] ADDR_PERIOD_UPPER = 6'h34;
    localparam logic [5:0] ADDR_STATUS = 6'h38;

    // Field widths and positions.
    localparam int CLOCK_CODE_W = 3;
    localparam int SOURCE_CODE_W = 5;
    localparam int COUNT_W = 24;
    localparam int SYNC_CHANNELS = 3;
    localparam int CH_CLOCK = 0;
    localparam int CH_WINDOW = 1;
    localparam int CH_SIGNAL = 2;

    // Number of selectable window and signal sources (code 0 is the pin).
    localparam int WINDOW_SOURCES = 24;
    localparam int SIGNAL_SOURCES = 25;

    // Codes that carry each instance's own period match output.
    localparam logic [4:0] MATCH_ONE_CODE = 5'h08;
    localparam logic [4:0] MATCH_TWO_CODE = 5'h09;

    // Values after reset.
    localparam logic [2:0] CLOCK_CODE_RESET = 3'h0;
    localparam logic [4:0] SOURCE_CODE_RESET = 5'h00;
    localparam logic [23:0] COUNT_RESET = 24'h000000;
    localparam logic [23:0] PERIOD_RESET = 24'hFFFFFF;

    // Control register layout, low bits of the word.
    typedef struct packed {
        logic clock_edge_polarity;
        logic signal_polarity;
        logic window_polarity;
        logic halt_on_period_match;
        logic enable;
    } sms_cfg_type;

    localparam sms_cfg_type CFG_RESET = '0;

endpackage : sms_pkg

// ---- rtl/sms_timer_sources.sv ----
`timescale 1ns/10ps
////////////////////////////////////////////////////////////////////////////////
// Signal measurement timer: source selectors, counter and capture latches.
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Clock code picks one of eight counting clocks.
// - Window code picks window input; high codes reserved.
// - Signal code picks measured signal; high codes reserved.
// - Own instance match code acts as reserved.
// - 24-bit counter, byte read/write, resets to zero.
// - Captured period latch, read-only, no reset value.
// - Captured width low byte, read-only, no reset.
// - Unused selector bits read zero, ignore writes.
// - Clock polarity picks rising or falling count edge.
// - Window and signal polarity invert active sense.
// - On period match hold or clear, pulse match.
module sms_timer_sources #(
    parameter bit INSTANCE_TWO = 1'b0
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Avalon-MM register slave.
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Candidate counting clocks, window sources and signal sources.
    input wire logic [7:0] count_clocks_i,
    input wire logic [sms_pkg::WINDOW_SOURCES-1:0] window_sources_i,
    input wire logic [sms_pkg::SIGNAL_SOURCES-1:0] signal_sources_i,
    // Period match pulse.
    output logic period_match_o
);
    import sms_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Declarations.
    ////////////////////////////////////////////////////////////////////////////
    logic [2:0] count_clock_code_r;         // Counting clock selector.
    logic [4:0] window_source_code_r;       // Window source selector.
    logic [4:0] signal_source_code_r;       // Signal source selector.
    sms_cfg_type cfg_r;                     // Enable, halt and polarities.
    logic [23:0] measure_counter_r;         // Running counter.
    logic [23:0] period_value_r;            // Period compare value.
    logic [23:0] captured_period_latch_r;   // Counter at signal active edge.
    logic [7:0] captured_width_latch_r;     // Counter low byte at inactive edge.
    logic waitrequest_r;                    // Bus stall, low for one answer cycle.
    logic [31:0] readdata_r;                // Registered read answer.
    logic period_match_r;                   // One-cycle match pulse.
    logic [SYNC_CHANNELS-1:0] raw;          // Selected, still asynchronous inputs.
    logic [SYNC_CHANNELS-1:0] s1_r;         // Synchroniser first stage.
    logic [SYNC_CHANNELS-1:0] s2_r;         // Synchroniser second stage.
    logic [SYNC_CHANNELS-1:0] s3_r;         // Synchroniser third stage.
    logic [SYNC_CHANNELS-1:0] stab_r;       // Agreed, filtered level.
    logic [SYNC_CHANNELS-1:0] rise;         // Filtered rising edge.
    logic [SYNC_CHANNELS-1:0] fall;         // Filtered falling edge.
    logic wr_ok;                            // Write taken this edge.
    logic rd_now;                           // Read answered this edge.
    logic [7:0] rd_byte;                    // Addressed register contents.
    logic clk_tick;                         // Counting edge of selected clock.
    logic window_open;                      // Window active after polarity.
    logic sig_start;                        // Signal active edge.
    logic sig_end;                          // Signal inactive edge.
    logic count_wr;                         // Software writes a counter byte.
    logic at_period;                        // Counter equals period value.

    // Picks a source by code; reserved codes and the own match code give 0.
    function automatic logic pick_source(input logic [24:0] src, input logic [4:0] code,
                                         input int count);
        logic own;
        own = INSTANCE_TWO ? (code == MATCH_TWO_CODE) : (code == MATCH_ONE_CODE);
        if (own || int'(code) >= count) begin
            pick_source = 1'b0;
        end else begin
            pick_source = src[code];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Source selection.
    ////////////////////////////////////////////////////////////////////////////
    // Selected sources feed the synchronisers; any select glitch is filtered there.
    always_comb begin
        raw[CH_CLOCK] = count_clocks_i[count_clock_code_r];
        raw[CH_WINDOW] = pick_source({1'b0, window_sources_i}, window_source_code_r,
                                     WINDOW_SOURCES);
        raw[CH_SIGNAL] = pick_source(signal_sources_i, signal_source_code_r,
                                     SIGNAL_SOURCES);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers and edge filters.
    ////////////////////////////////////////////////////////////////////////////
    // Three stages per channel; a level counts once stages two and three agree.
    genvar g;
    generate
        for (g = 0; g < SYNC_CHANNELS; g = g + 1) begin : g_sync
            always_ff @(posedge clock_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    s1_r[g] <= 1'b0;
                    s2_r[g] <= 1'b0;
                    s3_r[g] <= 1'b0;
                    stab_r[g] <= 1'b0;
                end else begin
                    s1_r[g] <= raw[g];
                    s2_r[g] <= s1_r[g];
                    s3_r[g] <= s2_r[g];
                    if (s2_r[g] == s3_r[g]) begin
                        stab_r[g] <= s3_r[g];
                    end
                end
            end
            assign rise[g] = (s2_r[g] == s3_r[g]) && s3_r[g] && !stab_r[g];
            assign fall[g] = (s2_r[g] == s3_r[g]) && !s3_r[g] && stab_r[g];
        end
    endgenerate

    // Polarity choices turn filtered edges and levels into events.
    always_comb begin
        clk_tick = cfg_r.clock_edge_polarity ? fall[CH_CLOCK] : rise[CH_CLOCK];
        window_open = stab_r[CH_WINDOW] ^ cfg_r.window_polarity;
        sig_start = cfg_r.enable && (cfg_r.signal_polarity ? fall[CH_SIGNAL]
                                                             : rise[CH_SIGNAL]);
        sig_end = cfg_r.enable && (cfg_r.signal_polarity ? rise[CH_SIGNAL]
                                                           : fall[CH_SIGNAL]);
        at_period = (measure_counter_r == period_value_r);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave.
    ////////////////////////////////////////////////////////////////////////////
    assign wr_ok = avs_write_i && !waitrequest_r && avs_byteenable_i[0];
    assign rd_now = avs_read_i && waitrequest_r;
    assign count_wr = wr_ok && (avs_address_i == ADDR_COUNT_LOW ||
                                avs_address_i == ADDR_COUNT_HIGH ||
                                avs_address_i == ADDR_COUNT_UPPER);

    // Read multiplexer; unmapped addresses answer zero.
    always_comb begin
        case (avs_address_i)
            ADDR_CLOCK_SEL: rd_byte = {5'h00, count_clock_code_r};
            ADDR_WINDOW_SEL: rd_byte = {3'h0, window_source_code_r};
            ADDR_SIGNAL_SEL: rd_byte = {3'h0, signal_source_code_r};
            ADDR_COUNT_LOW: rd_byte = measure_counter_r[7:0];
            ADDR_COUNT_HIGH: rd_byte = measure_counter_r[15:8];
            ADDR_COUNT_UPPER: rd_byte = measure_counter_r[23:16];
            ADDR_CAP_PERIOD_LOW: rd_byte = captured_period_latch_r[7:0];
            ADDR_CAP_PERIOD_HIGH: rd_byte = captured_period_latch_r[15:8];
            ADDR_CAP_PERIOD_UPPER: rd_byte = captured_period_latch_r[23:16];
            ADDR_CAP_WIDTH_LOW: rd_byte = captured_width_latch_r;
            ADDR_CONTROL: rd_byte = {3'h0, cfg_r};
            ADDR_PERIOD_LOW: rd_byte = period_value_r[7:0];
            ADDR_PERIOD_HIGH: rd_byte = period_value_r[15:8];
            ADDR_PERIOD_UPPER: rd_byte = period_value_r[23:16];
            ADDR_STATUS: rd_byte = {5'h00, stab_r[CH_SIGNAL], window_open, cfg_r.enable};
            default: rd_byte = 8'h00;
        endcase
    end

    // One wait cycle per access: waitrequest drops for one cycle, then rises.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            waitrequest_r <= 1'b1;
            readdata_r <= 32'h00000000;
        end else if ((avs_read_i || avs_write_i) && waitrequest_r) begin
            waitrequest_r <= 1'b0;
            if (rd_now) begin
                readdata_r <= {24'h000000, rd_byte};
            end
        end else begin
            waitrequest_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers.
    ////////////////////////////////////////////////////////////////////////////
    // Selector, control and period writes; upper selector bits are not stored.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_clock_code_r <= CLOCK_CODE_RESET;
            window_source_code_r <= SOURCE_CODE_RESET;
            signal_source_code_r <= SOURCE_CODE_RESET;
            cfg_r <= CFG_RESET;
            period_value_r <= PERIOD_RESET;
        end else if (wr_ok) begin
            case (avs_address_i)
                ADDR_CLOCK_SEL: count_clock_code_r <= avs_writedata_i[2:0];
                ADDR_WINDOW_SEL: window_source_code_r <= avs_writedata_i[4:0];
                ADDR_SIGNAL_SEL: signal_source_code_r <= avs_writedata_i[4:0];
                ADDR_CONTROL: cfg_r <= sms_cfg_type'(avs_writedata_i[4:0]);
                ADDR_PERIOD_LOW: period_value_r[7:0] <= avs_writedata_i[7:0];
                ADDR_PERIOD_HIGH: period_value_r[15:8] <= avs_writedata_i[7:0];
                ADDR_PERIOD_UPPER: period_value_r[23:16] <= avs_writedata_i[7:0];
                default: period_value_r <= period_value_r;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter.
    ////////////////////////////////////////////////////////////////////////////
    // Software writes win, then a signal start restarts, then a clock tick counts.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            measure_counter_r <= COUNT_RESET;
        end else if (count_wr) begin
            case (avs_address_i)
                ADDR_COUNT_LOW: measure_counter_r[7:0] <= avs_writedata_i[7:0];
                ADDR_COUNT_HIGH: measure_counter_r[15:8] <= avs_writedata_i[7:0];
                default: measure_counter_r[23:16] <= avs_writedata_i[7:0];
            endcase
        end else if (sig_start) begin
            measure_counter_r <= COUNT_RESET;
        end else if (cfg_r.enable && window_open && clk_tick) begin
            if (at_period) begin
                measure_counter_r <= cfg_r.halt_on_period_match ? period_value_r
                                                                : COUNT_RESET;
            end else begin
                measure_counter_r <= measure_counter_r + 24'h000001;
            end
        end
    end

    // Match pulse on every counting edge that finds the counter at the period.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            period_match_r <= 1'b0;
        end else begin
            period_match_r <= !count_wr && !sig_start && cfg_r.enable && window_open &&
                              clk_tick && at_period;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Capture latches.
    ////////////////////////////////////////////////////////////////////////////
    // No reset: contents are undefined until the first capture.
    always_ff @(posedge clock_i) begin
        if (sig_start) begin
            captured_period_latch_r <= measure_counter_r;
        end
        if (sig_end) begin
            captured_width_latch_r <= measure_counter_r[7:0];
        end
    end

    assign avs_readdata_o = readdata_r;
    assign avs_waitrequest_o = waitrequest_r;
    assign period_match_o = period_match_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    property p_clock_pick;
        s1_r[CH_CLOCK] == $past(count_clocks_i[count_clock_code_r]);
    endproperty
    a_clock_pick: assert property (p_clock_pick) else $error("clock source mismatch");

    property p_window_reserved;
        (window_source_code_r >= 5'h18) |-> ##3 !s3_r[CH_WINDOW] || $past(raw[CH_WINDOW], 3);
    endproperty
    a_window_reserved: assert property (p_window_reserved) else $error("window reserved");

    property p_signal_reserved;
        (signal_source_code_r > 5'h18) |-> !raw[CH_SIGNAL];
    endproperty
    a_signal_reserved: assert property (p_signal_reserved) else $error("signal reserved");

    property p_own_match;
        (window_source_code_r == (INSTANCE_TWO ? MATCH_TWO_CODE : MATCH_ONE_CODE))
            |-> !raw[CH_WINDOW];
    endproperty
    a_own_match: assert property (p_own_match) else $error("own match selected");

    property p_count_write;
        (wr_ok && avs_address_i == ADDR_COUNT_LOW)
            |=> measure_counter_r[7:0] == $past(avs_writedata_i[7:0]);
    endproperty
    a_count_write: assert property (p_count_write) else $error("counter write lost");

    property p_cap_readonly;
        (wr_ok && avs_address_i == ADDR_CAP_PERIOD_LOW && !sig_start)
            |=> $stable(captured_period_latch_r);
    endproperty
    a_cap_readonly: assert property (p_cap_readonly) else $error("latch written");

    property p_sel_zero;
        (rd_now && avs_address_i == ADDR_CLOCK_SEL) |=> avs_readdata_o[31:3] == 29'h0
            && !avs_waitrequest_o;
    endproperty
    a_sel_zero: assert property (p_sel_zero) else $error("selector upper bits set");

    property p_edge_dir;
        (clk_tick && cfg_r.enable) |=> stab_r[CH_CLOCK] == !$past(cfg_r.clock_edge_polarity);
    endproperty
    a_edge_dir: assert property (p_edge_dir) else $error("wrong clock edge");

    property p_halt;
        (cfg_r.enable && window_open && clk_tick && at_period && !count_wr && !sig_start)
            |=> period_match_o && measure_counter_r ==
                ($past(cfg_r.halt_on_period_match) ? $past(period_value_r) : COUNT_RESET);
    endproperty
    a_halt: assert property (p_halt) else $error("period match handling");

    property p_sync;
        $changed(stab_r[CH_SIGNAL]) |-> $past(s2_r[CH_SIGNAL] == s3_r[CH_SIGNAL]);
    endproperty
    a_sync: assert property (p_sync) else $error("unfiltered level change");

    // Ticks of one polarity are at least two cycles apart, so a match never doubles.
    property p_match_single;
        period_match_o |=> !period_match_o;
    endproperty
    a_match_single: assert property (p_match_single) else $error("match too long");

    // The inactive edge copies the counter low byte into the width latch.
    property p_width_capture;
        sig_end |=> captured_width_latch_r == $past(measure_counter_r[7:0]);
    endproperty
    a_width_capture: assert property (p_width_capture) else $error("width lost");

    // The active edge copies the counter and restarts it unless software writes it.
    property p_period_capture;
        (sig_start && !count_wr) |=> captured_period_latch_r == $past(measure_counter_r)
            && measure_counter_r == COUNT_RESET;
    endproperty
    a_period_capture: assert property (p_period_capture) else $error("period lost");

    // The upper counter byte takes the written value.
    property p_count_upper;
        (count_wr && avs_address_i == ADDR_COUNT_UPPER)
            |=> measure_counter_r[23:16] == $past(avs_writedata_i[7:0]);
    endproperty
    a_count_upper: assert property (p_count_upper) else $error("upper byte lost");

    // Every answer lowers waitrequest for exactly one cycle.
    property p_wait_one;
        !avs_waitrequest_o |=> avs_waitrequest_o;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest held low");

    c_match: cover property (period_match_o);
    c_capture: cover property (sig_start ##[1:200] sig_end);
    c_read: cover property (avs_read_i && !avs_waitrequest_o);
    c_halt_hold: cover property (period_match_o && cfg_r.halt_on_period_match);
    c_falling_count: cover property (clk_tick && cfg_r.clock_edge_polarity);

endmodule // sms_timer_sources

// ---- tb/sms_timer_sources_test.sv ----
`timescale 1ns/10ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; $display("FAIL at %0t got %0h expected %0h", $time, (g), (e)); end end
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench: register access, source selection, counting and capture.
////////////////////////////////////////////////////////////////////////////////
module sms_timer_sources_test;
    import sms_pkg::*;
    logic clock_i = 1'b0; // System clock, 5 ns period.
    logic rst_n_i = 1'b0; // Active low reset.
    logic [5:0] avs_address_i = 6'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h00000000;
    logic [3:0] avs_byteenable_i = 4'h0;
    logic [31:0] avs_readdata_o;
    logic avs_waitrequest_o;
    logic [7:0] count_clocks_i = 8'h00; // Candidate counting clocks.
    logic [WINDOW_SOURCES-1:0] window_sources_i = '0; // Window candidates.
    logic [SIGNAL_SOURCES-1:0] signal_sources_i = '0; // Signal candidates.
    logic period_match_o;
    int n_mismatch = 0; // Mismatches seen.
    int total_checks = 0; // Comparisons made.
    int cycles = 0; // Cycle count for the hang guard.
    int n_match = 0; // Period match pulses seen.
    int m0; // Pulse count at the start of a step.
    ////////////////////////////////////////////////////////////////////////////
    sms_timer_sources #(.INSTANCE_TWO(1'b0)) i_sms_timer_sources (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .count_clocks_i(count_clocks_i), .window_sources_i(window_sources_i),
        .signal_sources_i(signal_sources_i), .period_match_o(period_match_o));
    // Clock generator.
    initial begin
        forever #2.5 clock_i = ~clock_i;
    end
    // Counts match pulses and cuts a hung run short.
    always @(posedge clock_i) begin
        cycles++;
        if (period_match_o === 1'b1) n_match++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Bus write held until waitrequest is sampled low.
    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
        @(posedge clock_i);
        avs_address_i <= a;
        avs_writedata_i <= {24'h000000, d};
        avs_byteenable_i <= be;
        avs_write_i <= 1'b1;
        do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
        avs_write_i <= 1'b0;
    endtask
    // Bus read; data is taken at the edge where waitrequest is low.
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        logic [31:0] q;
        @(posedge clock_i);
        avs_address_i <= a;
        avs_read_i <= 1'b1;
        do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        `CHK(q, {24'h000000, e})
    endtask
    // Loads the counter byte by byte.
    task automatic wr_cnt(input logic [23:0] v);
        wr(ADDR_COUNT_LOW, v[7:0]);
        wr(ADDR_COUNT_HIGH, v[15:8]);
        wr(ADDR_COUNT_UPPER, v[23:16]);
    endtask
    // Reads the counter back byte by byte.
    task automatic chk_cnt(input logic [23:0] v);
        rd_chk(ADDR_COUNT_LOW, v[7:0]);
        rd_chk(ADDR_COUNT_HIGH, v[15:8]);
        rd_chk(ADDR_COUNT_UPPER, v[23:16]);
    endtask
    // Gives n slow pulses on one candidate clock, slow enough to be resolved.
    task automatic tog(input int c, input int n);
        repeat (n) begin
            @(posedge clock_i) count_clocks_i[c] <= 1'b1;
            repeat (4) @(posedge clock_i);
            count_clocks_i[c] <= 1'b0;
            repeat (4) @(posedge clock_i);
        end
        repeat (4) @(posedge clock_i);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        // Reset values of selectors and counter.
        rd_chk(ADDR_CLOCK_SEL, 8'h00);
        rd_chk(ADDR_WINDOW_SEL, 8'h00);
        rd_chk(ADDR_SIGNAL_SEL, 8'h00);
        chk_cnt(24'h000000);
        // Unused upper selector bits read zero; masked and unmapped access.
        wr(ADDR_CLOCK_SEL, 8'hFF);
        wr(ADDR_WINDOW_SEL, 8'hFF);
        wr(ADDR_SIGNAL_SEL, 8'hFF);
        rd_chk(ADDR_CLOCK_SEL, 8'h07);
        rd_chk(ADDR_WINDOW_SEL, 8'h1F);
        rd_chk(ADDR_SIGNAL_SEL, 8'h1F);
        wr(ADDR_CLOCK_SEL, 8'h02, 4'h0);
        rd_chk(ADDR_CLOCK_SEL, 8'h07);
        rd_chk(6'h3C, 8'h00);
        wr_cnt(24'hC35AA5);
        chk_cnt(24'hC35AA5);
        // Every clock code counts its own clock only, window pin held open.
        wr(ADDR_WINDOW_SEL, 8'h00);
        wr(ADDR_SIGNAL_SEL, 8'h00);
        window_sources_i[0] <= 1'b1;
        wr(ADDR_CONTROL, 8'h01);
        for (int c = 0; c < 8; c++) begin
            wr(ADDR_CLOCK_SEL, 8'(c));
            wr_cnt(24'h000000);
            tog((c + 1) % 8, 2);
            tog(c, 3);
            chk_cnt(24'h000003);
        end
        // Window selection: own match code is dead, the other one is live.
        wr(ADDR_CLOCK_SEL, 8'h02);
        wr(ADDR_WINDOW_SEL, {3'h0, MATCH_ONE_CODE});
        window_sources_i <= 24'h000300;
        wr_cnt(24'h000000);
        tog(2, 3);
        chk_cnt(24'h000000);
        wr(ADDR_WINDOW_SEL, {3'h0, MATCH_TWO_CODE});
        tog(2, 3);
        chk_cnt(24'h000003);
        // Window polarity set: a high window is closed.
        wr(ADDR_CONTROL, 8'h05);
        tog(2, 2);
        chk_cnt(24'h000003);
        // Clock polarity set: only the falling edge counts.
        wr(ADDR_CONTROL, 8'h11);
        wr_cnt(24'h000000);
        @(posedge clock_i) count_clocks_i[2] <= 1'b1;
        repeat (8) @(posedge clock_i);
        chk_cnt(24'h000000);
        count_clocks_i[2] <= 1'b0;
        repeat (8) @(posedge clock_i);
        chk_cnt(24'h000001);
        // Period match: wrap to zero, then hold with halt set.
        wr(ADDR_CONTROL, 8'h01);
        wr(ADDR_PERIOD_LOW, 8'h05);
        wr(ADDR_PERIOD_HIGH, 8'h00);
        wr(ADDR_PERIOD_UPPER, 8'h00);
        wr_cnt(24'h000000);
        m0 = n_match;
        tog(2, 6);
        chk_cnt(24'h000000);
        `CHK(n_match - m0, 1)
        wr(ADDR_CONTROL, 8'h03);
        wr_cnt(24'h000000);
        m0 = n_match;
        tog(2, 8);
        chk_cnt(24'h000005);
        `CHK(n_match - m0, 3)
        // Capture: window closed so the counter moves only by software writes and capture restarts.
        window_sources_i <= 24'h000000;
        wr(ADDR_SIGNAL_SEL, {3'h0, MATCH_ONE_CODE});
        wr_cnt(24'h123456);
        @(posedge clock_i) signal_sources_i[8] <= 1'b1;
        repeat (8) @(posedge clock_i);
        chk_cnt(24'h123456);
        wr(ADDR_SIGNAL_SEL, {3'h0, MATCH_TWO_CODE});
        signal_sources_i[9] <= 1'b1;
        repeat (8) @(posedge clock_i);
        rd_chk(ADDR_CAP_PERIOD_LOW, 8'h56);
        rd_chk(ADDR_CAP_PERIOD_HIGH, 8'h34);
        rd_chk(ADDR_CAP_PERIOD_UPPER, 8'h12);
        chk_cnt(24'h000000);
        wr(ADDR_COUNT_LOW, 8'h77);
        signal_sources_i[9] <= 1'b0;
        repeat (8) @(posedge clock_i);
        rd_chk(ADDR_CAP_WIDTH_LOW, 8'h77);
        // Latches ignore software writes.
        wr(ADDR_CAP_PERIOD_LOW, 8'hAA);
        wr(ADDR_CAP_WIDTH_LOW, 8'hAA);
        rd_chk(ADDR_CAP_PERIOD_LOW, 8'h56);
        rd_chk(ADDR_CAP_WIDTH_LOW, 8'h77);
        // Signal polarity set: the rising edge ends, the falling edge starts a capture.
        wr(ADDR_CONTROL, 8'h09);
        wr_cnt(24'h00ABCD);
        signal_sources_i[9] <= 1'b1;
        repeat (8) @(posedge clock_i);
        rd_chk(ADDR_CAP_PERIOD_LOW, 8'h56);
        rd_chk(ADDR_CAP_WIDTH_LOW, 8'hCD);
        signal_sources_i[9] <= 1'b0;
        repeat (8) @(posedge clock_i);
        rd_chk(ADDR_CAP_PERIOD_HIGH, 8'hAB);
        chk_cnt(24'h000000);
        summarize();
    end
endmodule // sms_timer_sources_test
